/* File: droop_pkg.sv */
// Constants, state encoding and helpers for the supply droop transmit hold-off block
package droop_pkg;

  // ****************************************************************
  // Clock and timebase
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;                  // 200 MHz system clock
  localparam int TIMEBASE_NS   = 10000;              // Recharge and duration timebase, 10 us
  localparam int TIMEBASE_CYC  = TIMEBASE_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Counter widths
  // ****************************************************************
  localparam int CNT_W  = 16;                        // Timebase ticks, saturating
  localparam int HOLD_W = CNT_W + 2;                 // Room for three times the rise time
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [HOLD_W-1:0] HOLD_ZERO = 18'h00000;
  localparam logic [1:0] HOLD_FACTOR = 2'h3;         // Hold-off is three rise times

  // ****************************************************************
  // Longest packet durations, in microseconds as specified
  // ****************************************************************
  localparam int PRI_C_US = 74600;
  localparam int PRI_A_US = 113800;
  localparam int SEC_C_US = 92200;
  localparam int SEC_A_US = 140700;
  localparam int US_PER_NS = 1000;

  // Longest time rounds down to whole timebase ticks
  localparam logic [CNT_W-1:0] PRI_C_TICKS = CNT_W'(PRI_C_US * US_PER_NS / TIMEBASE_NS);
  localparam logic [CNT_W-1:0] PRI_A_TICKS = CNT_W'(PRI_A_US * US_PER_NS / TIMEBASE_NS);
  localparam logic [CNT_W-1:0] SEC_C_TICKS = CNT_W'(SEC_C_US * US_PER_NS / TIMEBASE_NS);
  localparam logic [CNT_W-1:0] SEC_A_TICKS = CNT_W'(SEC_A_US * US_PER_NS / TIMEBASE_NS);

  // ****************************************************************
  // Controller states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SEND   = 4'h2,
    ST_CHARGE = 4'h4,
    ST_HOLD   = 4'h8
  } state_t;

  // Saturating increment of a tick counter
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == CNT_MAX) ? v : v + 16'h0001;
  endfunction

endpackage

/* File: recharge_if.sv */
// Carrier between the hold-off controller and the recharge meter
`timescale 1ns/10ps
`default_nettype none

interface recharge_if;
  logic                        below_low;   // Supply below lower threshold
  logic                        above_high;  // Supply above upper threshold
  logic                        restart;     // Discard previous measurement
  logic                        tick;        // Timebase tick
  logic [droop_pkg::CNT_W-1:0] rise_ticks;  // Measured rise time
  logic                        rise_done;   // Measurement complete

  modport meter (
    input  below_low,
    input  above_high,
    input  restart,
    output tick,
    output rise_ticks,
    output rise_done
  );

  modport ctrl (
    output below_low,
    output above_high,
    output restart,
    input  tick,
    input  rise_ticks,
    input  rise_done
  );
endinterface

`default_nettype wire

/* File: recharge_meter.sv */
// Timebase and supply recharge time measurement
`timescale 1ns/10ps
`default_nettype none

module recharge_meter #(
  parameter int TB_CYC = droop_pkg::TIMEBASE_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  recharge_if.meter m
);

  logic [15:0]                  tb_cnt_r;
  logic                         tick_r;
  logic                         low_q_r;
  logic                         running_r;
  logic                         done_r;
  logic [droop_pkg::CNT_W-1:0]  ticks_r;
  wire                          tb_wrap;
  wire                          low_release;

  // ****************************************************************
  // Fixed timebase
  // ****************************************************************
  assign tb_wrap = (tb_cnt_r == 16'(TB_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tb_cnt_r <= 16'h0000;
      tick_r   <= 1'b0;
    end else begin
      tb_cnt_r <= tb_wrap ? 16'h0000 : tb_cnt_r + 16'h0001;
      tick_r   <= tb_wrap;
    end
  end

  // ****************************************************************
  // Rise time: from leaving lower threshold to reaching upper one
  // ****************************************************************
  assign low_release = low_q_r & ~m.below_low;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_q_r   <= 1'b0;
      running_r <= 1'b0;
      done_r    <= 1'b0;
      ticks_r   <= droop_pkg::CNT_ZERO;
    end else begin
      low_q_r <= m.below_low;
      if (m.restart || m.below_low) begin
        running_r <= 1'b0;
        done_r    <= 1'b0;
        ticks_r   <= droop_pkg::CNT_ZERO;
      end else if (low_release) begin
        running_r <= 1'b1;
        ticks_r   <= droop_pkg::CNT_ZERO;
      end else if (running_r && m.above_high) begin
        running_r <= 1'b0;
        done_r    <= 1'b1;
      end else if (running_r && tick_r) begin
        ticks_r <= droop_pkg::sat_inc(ticks_r);  // Saturates, never wraps
      end
    end
  end

  assign m.tick       = tick_r;
  assign m.rise_ticks = ticks_r;
  assign m.rise_done  = done_r;

endmodule

`default_nettype wire

/* File: supply_droop_tx_holdoff.sv */
// Transmit hold-off controller driven by energy storage supply droop
`timescale 1ns/10ps
`default_nettype none

module supply_droop_tx_holdoff #(
  parameter int TB_CYC = droop_pkg::TIMEBASE_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pm_enable,           // Power-managed transceiver type selected
  input  wire logic band_a,              // 1: A band, 0: C band
  input  wire logic carrier_secondary,   // 1: secondary carrier in use
  input  wire logic supply_sense_input,  // Supply below lower threshold
  input  wire logic above_high,          // Supply above upper threshold
  input  wire logic tx_req,              // Transmitter holds a packet ready
  input  wire logic tx_end,              // Transmitter finished the packet
  output logic      tx_go,               // Start sending the packet, one cycle
  output logic      tx_abort,            // Stop the packet now, one cycle
  output logic      tx_retry,            // Next packet is the aborted one again
  output logic      tx_inhibit,          // Transmission withheld
  output logic      tx_overlong,         // Last abort was a duration overrun, one cycle
  output logic [droop_pkg::CNT_W-1:0] rise_ticks  // Rise time count, zero while supply is low, holds once upper threshold reached
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  recharge_if rif ();

  droop_pkg::state_t            state_r;
  droop_pkg::state_t            state_nxt;
  logic [droop_pkg::CNT_W-1:0]  dur_r;
  logic [droop_pkg::CNT_W-1:0]  dur_nxt;
  logic [droop_pkg::HOLD_W-1:0] hold_r;
  logic [droop_pkg::HOLD_W-1:0] hold_nxt;
  logic                         aborted_r;
  logic                         aborted_nxt;
  logic                         retry_r;
  logic                         retry_nxt;
  logic                         go_r;
  logic                         go_nxt;
  logic                         abort_r;
  logic                         abort_nxt;
  logic                         over_r;
  logic                         over_nxt;
  logic                         inhibit_r;
  logic [droop_pkg::CNT_W-1:0]  rise_r;

  wire                          low_seen;
  wire                          dur_limit_hit;
  wire [droop_pkg::CNT_W-1:0]   dur_limit;
  wire [droop_pkg::HOLD_W-1:0]  hold_load;
  wire                          enter_charge;

  // Longest allowed packet for the carrier and band in use
  function automatic logic [droop_pkg::CNT_W-1:0] packet_limit(input logic sec,
                                                               input logic a);
    case ({sec, a})
      2'h0:    packet_limit = droop_pkg::PRI_C_TICKS;
      2'h1:    packet_limit = droop_pkg::PRI_A_TICKS;
      2'h2:    packet_limit = droop_pkg::SEC_C_TICKS;
      default: packet_limit = droop_pkg::SEC_A_TICKS;
    endcase
  endfunction

  // ****************************************************************
  // Recharge meter
  // ****************************************************************
  recharge_meter #(
    .TB_CYC (TB_CYC)
  ) u_meter (
    .clk  (clk),
    .rstn (rstn),
    .m    (rif.meter)
  );

  // Comparator levels and meter restart
  assign rif.below_low  = supply_sense_input;
  assign rif.above_high = above_high;
  assign rif.restart    = enter_charge;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  // Droop detection is active only in the power-managed configuration; the recharge meter measures in both
  assign low_seen      = pm_enable & supply_sense_input;
  assign dur_limit     = packet_limit(carrier_secondary, band_a);
  assign dur_limit_hit = (dur_r >= dur_limit);
  assign hold_load     = {2'h0, rif.rise_ticks} * droop_pkg::HOLD_FACTOR;
  assign enter_charge  = (state_r != droop_pkg::ST_CHARGE) &&
                         (state_nxt == droop_pkg::ST_CHARGE);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    state_nxt   = state_r;
    dur_nxt     = dur_r;
    hold_nxt    = hold_r;
    aborted_nxt = aborted_r;
    retry_nxt   = retry_r;
    go_nxt      = 1'b0;
    abort_nxt   = 1'b0;
    over_nxt    = 1'b0;
    case (state_r)
      droop_pkg::ST_IDLE: begin
        if (low_seen) begin
          state_nxt = droop_pkg::ST_CHARGE;  // Withhold new packets
        end else if (tx_req) begin
          go_nxt    = 1'b1;  // Queued packets flow once charged
          dur_nxt   = droop_pkg::CNT_ZERO;
          state_nxt = droop_pkg::ST_SEND;
        end
      end
      droop_pkg::ST_SEND: begin
        if (rif.tick) begin
          dur_nxt = droop_pkg::sat_inc(dur_r);
        end
        if (low_seen) begin
          abort_nxt   = 1'b1;  // Cut the packet short
          aborted_nxt = 1'b1;
          retry_nxt   = 1'b1;  // Resend whatever the service type
          state_nxt   = droop_pkg::ST_CHARGE;
        end else if (tx_end) begin
          retry_nxt = 1'b0;
          state_nxt = droop_pkg::ST_IDLE;
        end else if (dur_limit_hit) begin
          abort_nxt = 1'b1;  // Never exceed the longest packet time
          over_nxt  = 1'b1;
          retry_nxt = 1'b0;
          state_nxt = droop_pkg::ST_IDLE;
        end
      end
      droop_pkg::ST_CHARGE: begin
        if (!pm_enable) begin
          aborted_nxt = 1'b0;
          state_nxt   = droop_pkg::ST_IDLE;
        end else if (rif.rise_done && !low_seen) begin  // Stale finish while low is ignored
          if (aborted_r) begin
            hold_nxt  = hold_load;
            state_nxt = droop_pkg::ST_HOLD;
          end else begin
            state_nxt = droop_pkg::ST_IDLE;  // Fully recharged
          end
        end
      end
      droop_pkg::ST_HOLD: begin
        if (low_seen) begin
          state_nxt = droop_pkg::ST_CHARGE;  // Fresh droop during hold-off
        end else if (!pm_enable || hold_r == droop_pkg::HOLD_ZERO) begin
          aborted_nxt = 1'b0;
          state_nxt   = droop_pkg::ST_IDLE;  // Retransmission allowed
        end else if (rif.tick) begin
          hold_nxt = hold_r - 18'h00001;
        end
      end
      default: begin
        state_nxt = droop_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r   <= droop_pkg::ST_IDLE;
      dur_r     <= droop_pkg::CNT_ZERO;
      hold_r    <= droop_pkg::HOLD_ZERO;
      aborted_r <= 1'b0;
      retry_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      dur_r     <= dur_nxt;
      hold_r    <= hold_nxt;
      aborted_r <= aborted_nxt;
      retry_r   <= retry_nxt;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      go_r      <= 1'b0;
      abort_r   <= 1'b0;
      over_r    <= 1'b0;
      inhibit_r <= 1'b0;
      rise_r    <= droop_pkg::CNT_ZERO;
    end else begin
      go_r      <= go_nxt;
      abort_r   <= abort_nxt;
      over_r    <= over_nxt;
      inhibit_r <= (state_nxt == droop_pkg::ST_CHARGE) ||
                   (state_nxt == droop_pkg::ST_HOLD);
      rise_r    <= rif.rise_ticks;
    end
  end

  assign tx_go       = go_r;
  assign tx_abort    = abort_r;
  assign tx_retry    = retry_r;
  assign tx_inhibit  = inhibit_r;
  assign tx_overlong = over_r;
  assign rise_ticks  = rise_r;

endmodule

`default_nettype wire

/* File: droop_checker.sv */
// Port assertions for the supply droop transmit hold-off controller
`timescale 1ns/10ps
`default_nettype none

module droop_checker #(
  parameter int TB_CYC = droop_pkg::TIMEBASE_CYC
) (
  input wire logic                        clk,
  input wire logic                        rstn,
  input wire logic                        pm_enable,
  input wire logic                        supply_sense_input,
  input wire logic                        tx_req,
  input wire logic                        tx_go,
  input wire logic                        tx_abort,
  input wire logic                        tx_retry,
  input wire logic                        tx_inhibit,
  input wire logic                        tx_overlong,
  input wire logic [droop_pkg::CNT_W-1:0] rise_ticks
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_start; tx_go; endsequence
  sequence s_droop_abort; tx_abort && !tx_overlong; endsequence
  property p_go_cause; s_start |-> $past(tx_req) && !$past(pm_enable && supply_sense_input);
  endproperty
  property p_go_pulse; s_start |=> !tx_go; endproperty
  property p_no_go_held; tx_inhibit |-> !tx_go; endproperty
  property p_droop_inhibit; pm_enable && supply_sense_input |=> tx_inhibit; endproperty
  property p_abort_cause; s_droop_abort |-> $past(supply_sense_input) && $past(pm_enable);
  endproperty
  property p_abort_retry; s_droop_abort |-> tx_retry && tx_inhibit; endproperty
  property p_overlong_pair; tx_overlong |-> tx_abort; endproperty
  property p_abort_pulse; tx_abort |=> !tx_abort; endproperty
  // Reported rise time only steps up by one or restarts from zero
  property p_rise_step;
    !$stable(rise_ticks) |-> (rise_ticks == droop_pkg::CNT_ZERO) ||
                             (rise_ticks == $past(rise_ticks) + 16'h0001);
  endproperty
  a_go_cause: assert property (p_go_cause)
    else $error("start without a taken request");
  a_go_pulse: assert property (p_go_pulse)
    else $error("start pulse longer than one cycle");
  a_no_go_held: assert property (p_no_go_held)
    else $error("start while withheld");
  a_droop_inhibit: assert property (p_droop_inhibit)
    else $error("low supply did not withhold");
  a_abort_cause: assert property (p_abort_cause)
    else $error("abort without low supply");
  a_abort_retry: assert property (p_abort_retry)
    else $error("droop abort without retry and inhibit");
  a_overlong_pair: assert property (p_overlong_pair)
    else $error("overrun flag without abort");
  a_abort_pulse: assert property (p_abort_pulse)
    else $error("abort pulse longer than one cycle");
  a_rise_step: assert property (p_rise_step)
    else $error("rise time jumped instead of counting");
endmodule

bind supply_droop_tx_holdoff droop_checker #(.TB_CYC(TB_CYC)) u_chk (.clk(clk), .rstn(rstn),
  .pm_enable(pm_enable), .supply_sense_input(supply_sense_input), .tx_req(tx_req),
  .tx_go(tx_go), .tx_abort(tx_abort), .tx_retry(tx_retry), .tx_inhibit(tx_inhibit),
  .tx_overlong(tx_overlong), .rise_ticks(rise_ticks));

`default_nettype wire

/* File: tx_model.sv */
// Packet transmitter model facing the hold-off controller
`timescale 1ns/10ps
`default_nettype none

module tx_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        want,
  input  wire logic [15:0] len,
  input  wire logic        tx_go,
  input  wire logic        tx_abort,
  input  wire logic        tx_retry,
  output var  logic        tx_req,
  output var  logic        tx_end
);
  logic [15:0] cnt;
  logic        busy;

  // Hold request until started, send len+1 cycles, requeue a packet marked for retry
  always @(posedge clk) begin
    if (!rstn) begin
      tx_req <= 1'b0;
      tx_end <= 1'b0;
      busy   <= 1'b0;
      cnt    <= 16'h0000;
    end else begin
      tx_end <= 1'b0;
      if (tx_go) begin
        tx_req <= 1'b0;
        busy   <= 1'b1;
        cnt    <= len;
      end else if (busy && tx_abort) begin
        busy   <= 1'b0;
        tx_req <= tx_retry;  // An overrun abort drops the packet
      end else if (busy && cnt == 16'h0000) begin
        busy   <= 1'b0;
        tx_end <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 16'h0001;
      end else if (want) begin
        tx_req <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the supply droop transmit hold-off controller
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam int TB = 2;
  localparam int R  = 6;
  typedef struct {logic pm; logic ba; logic cs; logic ss; logic inh;} row_t;
  row_t rows[4] = '{'{0, 0, 0, 0, 0}, '{0, 1, 1, 1, 0}, '{1, 0, 1, 0, 0}, '{1, 1, 0, 0, 0}};
  logic clk = 1'b0, rstn = 1'b0, pm_enable = 1'b0, band_a = 1'b0, carrier_secondary = 1'b0;
  logic supply_sense_input = 1'b0, above_high = 1'b0, want = 1'b0;
  logic [15:0] len = 16'h000A;
  logic tx_req, tx_end, tx_go, tx_abort, tx_retry, tx_inhibit, tx_overlong;
  logic [droop_pkg::CNT_W-1:0] rise_ticks;
  int num_errors = 0, checks_done = 0, gos = 0, n, g;

  always #2.5 clk = ~clk;
  always @(posedge clk) if (tx_go === 1'b1) gos++;

  supply_droop_tx_holdoff #(.TB_CYC(TB)) i_dut (.clk, .rstn, .pm_enable, .band_a,
    .carrier_secondary, .supply_sense_input, .above_high, .tx_req, .tx_end, .tx_go,
    .tx_abort, .tx_retry, .tx_inhibit, .tx_overlong, .rise_ticks);
  tx_model i_tx (.clk, .rstn, .want, .len, .tx_go, .tx_abort, .tx_retry, .tx_req, .tx_end);

  // ****
  // Tasks
  // ****
  task chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task chk_rng(input logic [31:0] got, input int lo, input int hi);
    checks_done++;
    if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task drive(input logic p, input logic a, input logic c, input logic s, input logic h);
    @(posedge clk);
    pm_enable <= p;
    band_a <= a;
    carrier_secondary <= c;
    supply_sense_input <= s;
    above_high <= h;
  endtask
  task req(input logic [15:0] l);
    @(posedge clk);
    want <= 1'b1;
    len <= l;
    @(posedge clk);
    want <= 1'b0;
  endtask
  // Count cycles until the start pulse, bounded
  task wait_go;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (tx_go !== 1'b1 && n < 40000);
  endtask
  // Count cycles until the abort pulse, bounded
  task wait_abort;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (tx_abort !== 1'b1 && n < 40000);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #300000;
    num_errors++;
    test_done;
  end

  initial begin
    cyc(5);
    rstn <= 1'b1;
    // Plain packets, with and without power management
    foreach (rows[i]) begin
      drive(rows[i].pm, rows[i].ba, rows[i].cs, rows[i].ss, 1'b1);
      req(16'h000A);
      wait_go;
      chk_rng(n, 1, 2);
      chk_bit(tx_inhibit, rows[i].inh);
      chk_bit(tx_retry, 1'b0);
      cyc(14);
    end
    $display("test rows done");
    // Droop while idle withholds until the upper threshold
    drive(1, 0, 0, 1, 0);
    cyc(2);
    #1 chk_bit(tx_inhibit, 1'b1);
    g = gos;
    req(16'h000A);
    cyc(20);
    chk_rng(gos - g, 0, 0);
    drive(1, 0, 0, 0, 0);
    cyc(3);
    drive(1, 0, 0, 0, 1);
    wait_go;
    chk_rng(n, 1, 8);
    chk_bit(tx_retry, 1'b0);
    cyc(14);
    $display("test idle droop done");
    // Droop mid-packet aborts, hold-off is three rise times, packet resent
    drive(1, 0, 0, 0, 0);
    req(16'h0190);
    wait_go;
    cyc(5);
    drive(1, 0, 0, 1, 0);
    @(posedge clk);
    #1 chk_bit(tx_abort, 1'b1);
    chk_bit(tx_retry, 1'b1);
    chk_bit(tx_inhibit, 1'b1);
    cyc(3);
    drive(1, 0, 0, 0, 0);
    cyc(R * TB - 1);
    drive(1, 0, 0, 0, 1);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (tx_inhibit !== 1'b0 && n < 2000);
    chk_rng(32'(rise_ticks), R - 1, R + 1);
    chk_rng(n, 3 * (R - 1) * TB, 3 * (R + 1) * TB + TB + 6);
    wait_go;
    chk_rng(n, 1, 4);
    chk_bit(tx_retry, 1'b1);
    cyc(410);
    #1 chk_bit(tx_retry, 1'b0);
    $display("test droop abort done");
    // Primary C band packet overruns 74.6 ms, 7460 ticks
    req(16'h9C40);
    wait_go;
    wait_abort;
    chk_rng(n, 7459 * TB, 7460 * TB + 4);
    chk_bit(tx_overlong, 1'b1);
    chk_bit(tx_retry, 1'b0);
    // Secondary A band packet overruns 140.7 ms, 14070 ticks
    drive(1, 1, 1, 0, 0);
    req(16'h9C40);
    wait_go;
    wait_abort;
    chk_rng(n, 14069 * TB, 14070 * TB + 4);
    chk_bit(tx_overlong, 1'b1);
    chk_bit(tx_retry, 1'b0);
    $display("test overrun done");
    // Leaving power-managed mode while charging frees the transmitter
    drive(1, 0, 0, 1, 0);
    cyc(2);
    #1 chk_bit(tx_inhibit, 1'b1);
    drive(0, 0, 0, 1, 0);
    cyc(2);
    #1 chk_bit(tx_inhibit, 1'b0);
    $display("test mode drop done");
    // Reset after a droop abort clears everything, first request served
    drive(1, 0, 0, 0, 0);
    req(16'h0190);
    wait_go;
    drive(1, 0, 0, 1, 0);
    @(posedge clk);
    #1 chk_bit(tx_abort, 1'b1);
    @(posedge clk);
    rstn <= 1'b0;
    cyc(3);
    drive(1, 0, 0, 0, 1);
    cyc(2);
    #1 chk_bit(tx_inhibit, 1'b0);
    chk_bit(tx_retry, 1'b0);
    chk_rng(32'(rise_ticks), 0, 0);
    @(posedge clk);
    rstn <= 1'b1;
    req(16'h000A);
    wait_go;
    chk_rng(n, 1, 1);
    chk_bit(tx_retry, 1'b0);
    $display("test reset done");
    test_done;
  end
endmodule

`default_nettype wire
